// [design/ipmc_top.sv]
// Interrupt controller with brown-out path and idle and power-down modes.
// Contract
// - Filtered low supply raises brown-out event; enabled interrupt keeps running.
// - Brown-out without its interrupt enabled resets the core.
// - Low supply must persist four clocks before the detector acts.
// - Aux enable bit 3 at E8H routes brown-out to vector 004BH.
// - Clearing brown-out enable while condition active resets the core.
// - Disabled brown-out restarts execution at 0000H.
// - Four priority levels, per-source enable and two priority bits.
// - External interrupt 0 polled first, vector 0003H, wakes power-down.
// - External interrupt 1 polled fourth, vector 0013H, wakes power-down.
// - Timer 1 polled fifth, vector 001BH.
// - Counter array sixth 0033H; external 2 and 3 at 003BH, 0043H.
// - Serial shares 0023H polled ninth; timer 2 last at 002BH.
// - Idle request bit 0 halts the program counter only.
// - Idle holds address latch and program store strobes high.
// - Interrupt in idle clears idle request; return resumes after it.
// - Power-down bit 1 stops clock; only level external interrupts live.
// - Power-down drives both strobes low.
// - Power-down left by enabled level interrupt or reset, clearing request.
// - Wake pin held low 1024 clocks; service starts when pin rises.
// - Hardware reset in idle or power-down restarts like power-on.
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module ipmc_top
  import ipmc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic brownout_low,
  input wire logic ext_int0_n,
  input wire logic ext_int1_n,
  input wire logic [1:0] ext_int_level_mode,
  input wire logic [NSRC-1:0] src_flags,
  input wire logic [15:0] core_pc,
  input wire logic core_reti,
  output logic [15:0] core_vector,
  output logic core_vector_take,
  output logic core_reset,
  output logic core_pc_halt,
  output logic core_clock_stop,
  output logic addr_latch_strobe,
  output logic program_store_strobe_n,
  output logic [15:0] core_return_addr
);
  typedef struct packed {
    logic awdone;
    logic wdone;
    logic awready;
    logic wready;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] aux_int_enable_reg;
    logic [NSRC-1:0] enables;
    logic [2*NSRC-1:0] prio;
    logic [1:0] power_control_reg;
    ipmc_mode_e mode;
    logic [10:0] wake_cnt;
    logic [1:0] wake_pend;
    logic [2:0] level_stack;
    logic [4*2-1:0] saved_lvl;
    logic [2*16-1:0] saved_pc;
    logic [1:0] depth;
    logic [15:0] vector;
    logic take;
    logic reset_pulse;
    logic bo_seen;
    logic halt;
    logic stop;
    logic ale;
    logic pss_n;
    logic [15:0] ret_addr;
  } ipmc_state_s;

  ipmc_state_s r;
  ipmc_state_s next_r;
  logic bo_level;
  logic int0_low;
  logic int1_low;
  logic [NSRC-1:0] pending;
  logic found;
  logic [3:0] win_index;
  logic [1:0] win_level;
  logic [15:0] vec_table [NSRC];
  logic [NSRC-1:0] raw;
  logic in_service;
  logic [1:0] cur_level;
  logic grant;

  ipmc_sync #(.STABLE(BO_FILTER_CLKS)) u_bo_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(brownout_low),
    .level(bo_level)
  );

  ipmc_sync #(.STABLE(1)) u_int0_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(~ext_int0_n),
    .level(int0_low)
  );

  ipmc_sync #(.STABLE(1)) u_int1_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(~ext_int1_n),
    .level(int1_low)
  );

  // Polling order: ext0, brown-out, t0, ext1, t1, array, ext2, ext3, serial, t2.
  assign vec_table[0] = VEC_EXT0;
  assign vec_table[1] = VEC_BO;
  assign vec_table[2] = VEC_T0;
  assign vec_table[3] = VEC_EXT1;
  assign vec_table[4] = VEC_T1;
  assign vec_table[5] = VEC_CA;
  assign vec_table[6] = VEC_EXT2;
  assign vec_table[7] = VEC_EXT3;
  assign vec_table[8] = VEC_SER;
  assign vec_table[9] = VEC_T2;

  always_comb begin
    raw = src_flags;
    raw[0] = src_flags[0] | int0_low | r.wake_pend[0];
    raw[1] = bo_level & r.aux_int_enable_reg[BO_ENABLE_BIT];
    raw[3] = src_flags[3] | int1_low | r.wake_pend[1];
  end

  assign in_service = r.depth != 2'h0;
  assign cur_level = r.saved_lvl[1:0];
  assign pending = raw & r.enables;
  // A request wins when nothing is served or it outranks the running level.
  assign grant = found && (!in_service || win_level > cur_level);

  ipmc_arbiter u_arb (
    .pending(pending),
    .prio(r.prio),
    .found(found),
    .index(win_index),
    .level(win_level)
  );

  always_comb begin
    logic [31:0] rd;
    logic wr;
    logic [1:0] wake;
    rd = 32'h0;
    wr = 1'b0;
    wake = 2'h0;
    next_r = r;
    next_r.take = 1'b0;
    next_r.reset_pulse = 1'b0;
    next_r.bvalid = r.bvalid & ~s_axi_bready;
    next_r.rvalid = r.rvalid & ~s_axi_rready;
    next_r.arready = 1'b0;
    if (s_axi_awvalid && !r.awdone) begin
      next_r.awdone = 1'b1;
      next_r.waddr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && !r.wdone) begin
      next_r.wdone = 1'b1;
      next_r.wdata = s_axi_wdata;
    end
    wr = r.awdone && r.wdone && !r.bvalid;
    if (wr) begin
      next_r.awdone = 1'b0;
      next_r.wdone = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = RESP_OKAY;
      case (r.waddr)
        REG_ENABLE: next_r.enables = r.wdata[NSRC-1:0];
        REG_PRIO_LO: next_r.prio[15:0] = r.wdata[15:0];
        REG_PRIO_HI: next_r.prio[19:16] = r.wdata[3:0];
        REG_POWER_CTRL: next_r.power_control_reg = r.wdata[1:0];
        REG_AUX_INT_ENABLE: next_r.aux_int_enable_reg = r.wdata[7:0];
        REG_STATUS: next_r.bresp = RESP_OKAY;
        default: next_r.bresp = RESP_SLVERR;
      endcase
    end
    if (s_axi_arvalid && !r.arready && !r.rvalid) begin
      next_r.arready = 1'b1;
      next_r.rvalid = 1'b1;
      next_r.rresp = RESP_OKAY;
      case (s_axi_araddr[7:0])
        REG_ENABLE: rd = 32'(r.enables);
        REG_PRIO_LO: rd = {16'h0, r.prio[15:0]};
        REG_PRIO_HI: rd = {28'h0, r.prio[19:16]};
        REG_POWER_CTRL: rd = {30'h0, r.power_control_reg};
        REG_AUX_INT_ENABLE: rd = {24'h0, r.aux_int_enable_reg};
        REG_STATUS: rd = {16'h0, r.ret_addr[7:0], 1'b0, bo_level,
                          r.depth, r.level_stack[0], r.mode, 1'b0};
        default: next_r.rresp = RESP_SLVERR;
      endcase
      next_r.rdata = rd;
    end
    // The brown-out enable bit always mirrors the auxiliary enable bit.
    next_r.enables[1] = next_r.aux_int_enable_reg[BO_ENABLE_BIT];
    // Brown-out without its enable resets and restarts at address zero.
    if (bo_level && !next_r.aux_int_enable_reg[BO_ENABLE_BIT]) begin
      if (!r.bo_seen) begin
        next_r.reset_pulse = 1'b1;
        next_r.vector = VEC_RESET;
        next_r.depth = 2'h0;
        next_r.mode = IPMC_RUN;
        next_r.power_control_reg = 2'h0;
        next_r.wake_cnt = 11'h0;
        next_r.wake_pend = 2'h0;
        next_r.level_stack = 3'h0;
        next_r.saved_lvl = 8'h0;
        next_r.saved_pc = 32'h0;
      end
      next_r.bo_seen = 1'b1;
    end else if (!bo_level) begin
      next_r.bo_seen = 1'b0;
    end
    case (r.mode)
      IPMC_RUN: begin
        if (next_r.power_control_reg[PDOWN_BIT]) begin
          next_r.mode = IPMC_PDOWN;
          next_r.wake_cnt = 11'h0;
        end else if (next_r.power_control_reg[IDLE_BIT]) begin
          next_r.mode = IPMC_IDLE;
        end
      end
      IPMC_IDLE: begin
        if (grant) begin
          next_r.power_control_reg[IDLE_BIT] = 1'b0;
          next_r.mode = IPMC_RUN;
        end
      end
      IPMC_PDOWN: begin
        // Only enabled level-mode external pins count the wake hold.
        wake[0] = int0_low && r.enables[0] && ext_int_level_mode[0];
        wake[1] = int1_low && r.enables[3] && ext_int_level_mode[1];
        // The waking pin is latched so its vector is served after it rises.
        if (wake != 2'h0) begin
          next_r.wake_pend = r.wake_pend | wake;
          if (r.wake_cnt < 11'(WAKE_HOLD_CLKS)) begin
            next_r.wake_cnt = r.wake_cnt + 11'h1;
          end
        end else if (r.wake_cnt >= 11'(WAKE_HOLD_CLKS)) begin
          next_r.power_control_reg[PDOWN_BIT] = 1'b0;
          next_r.mode = IPMC_RUN;
        end else begin
          next_r.wake_cnt = 11'h0;
          next_r.wake_pend = 2'h0;
        end
      end
      default: next_r.mode = IPMC_RUN;
    endcase
    // Dispatch to the core, blocked while the clock is stopped.
    // A return in the same cycle goes first so the depth stays exact.
    if (r.mode != IPMC_PDOWN && next_r.mode != IPMC_PDOWN && !r.take &&
        grant && r.depth != 2'h2 && !next_r.reset_pulse &&
        !core_reti) begin
      next_r.take = 1'b1;
      next_r.vector = vec_table[win_index];
      next_r.saved_pc = {r.saved_pc[15:0], core_pc};
      next_r.saved_lvl = {r.saved_lvl[5:0], win_level};
      next_r.depth = r.depth + 2'h1;
      next_r.ret_addr = core_pc;
      next_r.level_stack = {r.level_stack[1:0], 1'b1};
      // Serving a woken pin retires its latched request.
      if (win_index == 4'h0) begin
        next_r.wake_pend[0] = 1'b0;
      end
      if (win_index == 4'h3) begin
        next_r.wake_pend[1] = 1'b0;
      end
    end else if (core_reti && in_service && !next_r.reset_pulse) begin
      // Return pops the stored address and the served level, restoring the level it interrupted.
      next_r.ret_addr = r.saved_pc[15:0];
      next_r.saved_pc = {16'h0, r.saved_pc[31:16]};
      next_r.saved_lvl = {2'h0, r.saved_lvl[7:2]};
      next_r.depth = r.depth - 2'h1;
      next_r.level_stack = {1'b0, r.level_stack[2:1]};
    end
    next_r.halt = next_r.mode != IPMC_RUN;
    next_r.stop = next_r.mode == IPMC_PDOWN;
    next_r.ale = next_r.mode != IPMC_PDOWN;
    next_r.pss_n = next_r.mode != IPMC_PDOWN;
    next_r.awready = !next_r.awdone;
    next_r.wready = !next_r.wdone;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      // Reset leaves both ready signals and both strobes high.
      r.awready <= 1'b1;
      r.wready <= 1'b1;
      r.ale <= 1'b1;
      r.pss_n <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign s_axi_awready = r.awready;
  assign s_axi_wready = r.wready;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = r.arready;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign core_vector = r.vector;
  assign core_vector_take = r.take;
  assign core_reset = r.reset_pulse;
  assign core_pc_halt = r.halt;
  assign core_clock_stop = r.stop;
  assign addr_latch_strobe = r.ale;
  assign program_store_strobe_n = r.pss_n;
  assign core_return_addr = r.ret_addr;
endmodule : ipmc_top

// [design/ipmc_pkg.sv]
// Package of constants and types for the interrupt and power mode controller.
package ipmc_pkg;
  localparam int NSRC = 10;
  localparam logic [7:0] REG_ENABLE = 8'h00;
  localparam logic [7:0] REG_PRIO_LO = 8'h04;
  localparam logic [7:0] REG_PRIO_HI = 8'h08;
  localparam logic [7:0] REG_POWER_CTRL = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_AUX_INT_ENABLE = 8'hE8;
  localparam int BO_ENABLE_BIT = 3;
  localparam int IDLE_BIT = 0;
  localparam int PDOWN_BIT = 1;
  localparam int BO_FILTER_CLKS = 4;
  localparam int CLK_PERIOD_NS = 10;
  localparam int WAKE_HOLD_CLKS = 1024;
  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam logic [15:0] VEC_EXT0 = 16'h0003;
  localparam logic [15:0] VEC_BO = 16'h004B;
  localparam logic [15:0] VEC_T0 = 16'h000B;
  localparam logic [15:0] VEC_EXT1 = 16'h0013;
  localparam logic [15:0] VEC_T1 = 16'h001B;
  localparam logic [15:0] VEC_CA = 16'h0033;
  localparam logic [15:0] VEC_EXT2 = 16'h003B;
  localparam logic [15:0] VEC_EXT3 = 16'h0043;
  localparam logic [15:0] VEC_SER = 16'h0023;
  localparam logic [15:0] VEC_T2 = 16'h002B;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    IPMC_RUN = 2'h0,
    IPMC_IDLE = 2'h1,
    IPMC_PDOWN = 2'h2
  } ipmc_mode_e;

  typedef struct packed {
    logic [15:0] vector;
    logic take;
  } ipmc_req_s;
endpackage : ipmc_pkg

// [design/ipmc_sync.sv]
// Three-stage pin synchroniser with a filter that needs a stable run.
`timescale 1ns/1ps
module ipmc_sync
  import ipmc_pkg::*;
#(
  parameter int STABLE = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin,
  output logic level
);
  typedef struct packed {
    logic [2:0] sync;
    logic [3:0] cnt;
    logic level;
  } ipmc_sync_s;
  ipmc_sync_s r;
  ipmc_sync_s next_r;

  always_comb begin
    next_r = r;
    next_r.sync = {r.sync[1:0], pin};
    if (r.sync[2] == r.sync[1] && r.sync[2] != r.level) begin
      if (r.cnt >= 4'(STABLE - 1)) begin
        next_r.level = r.sync[2];
        next_r.cnt = 4'h0;
      end else begin
        next_r.cnt = r.cnt + 4'h1;
      end
    end else begin
      next_r.cnt = 4'h0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign level = r.level;
endmodule : ipmc_sync

// [design/ipmc_arbiter.sv]
// Four-level priority arbiter with fixed polling order inside a level.
`timescale 1ns/1ps
module ipmc_arbiter
  import ipmc_pkg::*;
(
  input wire logic [NSRC-1:0] pending,
  input wire logic [2*NSRC-1:0] prio,
  output logic found,
  output logic [3:0] index,
  output logic [1:0] level
);
  always_comb begin
    found = 1'b0;
    index = 4'h0;
    level = 2'h0;
    for (int i = 0; i < NSRC; i++) begin
      if (pending[i] && (!found || prio[2*i +: 2] > level)) begin
        found = 1'b1;
        index = 4'(i);
        level = prio[2*i +: 2];
      end
    end
  end
endmodule : ipmc_arbiter

// [tb/ipmc_sva.sv]
// Assertion checker for the interrupt and power mode controller.
`timescale 1ns/1ps
module ipmc_sva
  import ipmc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic brownout_low,
  input wire logic ext_int0_n,
  input wire logic ext_int1_n,
  input wire logic [15:0] core_vector,
  input wire logic core_vector_take,
  input wire logic core_reset,
  input wire logic core_pc_halt,
  input wire logic core_clock_stop,
  input wire logic addr_latch_strobe,
  input wire logic program_store_strobe_n
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [3:0] lo_run;
  logic [10:0] pin_run;
  logic bo_seen;
  logic wake_ok;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lo_run <= 4'h0;
      pin_run <= 11'h000;
      bo_seen <= 1'b0;
      wake_ok <= 1'b0;
    end else begin
      lo_run <= brownout_low ? lo_run + {3'h0, lo_run != 4'hF} : 4'h0;
      pin_run <= (!ext_int0_n || !ext_int1_n) ?
        pin_run + {10'h000, pin_run != 11'h7FF} : 11'h000;
      bo_seen <= !core_reset && (bo_seen || lo_run >= 4'h4);
      wake_ok <= core_clock_stop && (wake_ok || pin_run >= 11'h400);
    end
  end
  AST_PD_STROBES: assert property (core_clock_stop |->
    !addr_latch_strobe && !program_store_strobe_n)
    else $error("strobes not low in power-down");
  AST_IDLE_STROBES: assert property (core_pc_halt && !core_clock_stop |->
    addr_latch_strobe && program_store_strobe_n)
    else $error("strobes not high in idle");
  AST_PD_HALT: assert property (core_clock_stop |-> core_pc_halt)
    else $error("power-down without halt");
  AST_TAKE_GAP: assert property (core_vector_take |=> !core_vector_take)
    else $error("dispatch pulses back to back");
  AST_RST_VEC: assert property (core_reset |-> core_vector == VEC_RESET)
    else $error("reset without zero vector");
  AST_RST_NO_TAKE: assert property (core_reset |-> !core_vector_take)
    else $error("reset together with dispatch");
  AST_BO_FILTER: assert property (core_reset |-> bo_seen)
    else $error("reset without four low supply clocks");
  AST_WAKE_HOLD: assert property ($fell(core_clock_stop) |-> wake_ok)
    else $error("power-down left without long pin hold");
  AST_VEC_HOLD: assert property ($changed(core_vector) |->
    core_vector_take || core_reset)
    else $error("vector changed without dispatch");
  AST_IDLE_EXIT: assert property (core_vector_take |-> ##[0:2] !core_pc_halt)
    else $error("dispatch left halt set");
  COV_RST: cover property (core_reset);
  COV_BO: cover property (core_vector_take && core_vector == VEC_BO);
  COV_WAKE: cover property ($fell(core_clock_stop));
endmodule : ipmc_sva
bind ipmc_top ipmc_sva i_sva (.aclk(aclk), .aresetn(aresetn),
  .brownout_low(brownout_low), .ext_int0_n(ext_int0_n),
  .ext_int1_n(ext_int1_n), .core_vector(core_vector),
  .core_vector_take(core_vector_take), .core_reset(core_reset),
  .core_pc_halt(core_pc_halt), .core_clock_stop(core_clock_stop),
  .addr_latch_strobe(addr_latch_strobe),
  .program_store_strobe_n(program_store_strobe_n));

// [tb/ipmc_core_model.sv]
// Behavioural processor core that runs, services vectors and returns.
`timescale 1ns/1ps
module ipmc_core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic take,
  input wire logic halt,
  input wire logic [3:0] svc_len,
  output logic [15:0] pc,
  output logic reti
);
  logic [3:0] stk[$];
  always @(posedge aclk) begin
    reti <= 1'b0;
    if (!aresetn) begin
      pc <= 16'h0000;
      stk.delete();
    end else begin
      if (!halt) pc <= pc + 16'h0001;
      if (stk.size() != 0) begin
        if (stk[$] == 4'h0) begin
          reti <= 1'b1;
          void'(stk.pop_back());
        end else stk[$] = stk[$] - 4'h1;
      end
      if (take) stk.push_back(svc_len);
    end
  end
endmodule : ipmc_core_model

// [tb/tb_interrupt_power_mode_control.sv]
// Self-checking bench for the interrupt and power mode controller.
`timescale 1ns/1ps
module tb_interrupt_power_mode_control;
  import ipmc_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
  logic [31:0] s_axi_araddr = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, core_vector_take, core_reset, core_pc_halt;
  logic core_clock_stop, addr_latch_strobe, program_store_strobe_n;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic brownout_low = 1'b0, ext_int0_n = 1'b1, ext_int1_n = 1'b1;
  logic [1:0] ext_int_level_mode = 2'h3;
  logic [NSRC-1:0] src_flags = 10'h000;
  logic [15:0] core_pc, core_vector, core_return_addr;
  logic core_reti;
  logic [15:0] pc_prev;
  logic [3:0] svc_len = 4'h5;
  int n_mismatch = 0;
  int samples_checked = 0;
  logic [15:0] expq[$];
  localparam logic [15:0] VT [NSRC] = '{VEC_EXT0, VEC_BO, VEC_T0,
    VEC_EXT1, VEC_T1, VEC_CA, VEC_EXT2, VEC_EXT3, VEC_SER, VEC_T2};
  always #5 aclk = ~aclk;
  ipmc_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .brownout_low,
    .ext_int0_n, .ext_int1_n, .ext_int_level_mode, .src_flags, .core_pc,
    .core_reti, .core_vector, .core_vector_take, .core_reset,
    .core_pc_halt, .core_clock_stop, .addr_latch_strobe,
    .program_store_strobe_n, .core_return_addr);
  ipmc_core_model i_core (.aclk, .aresetn, .take(core_vector_take),
    .halt(core_pc_halt), .svc_len, .pc(core_pc), .reti(core_reti));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    @(posedge aclk);
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      aw = aw && s_axi_awready !== 1'b1;
      w = w && s_axi_wready !== 1'b1;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, RESP_OKAY});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
    input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, r});
  endtask : rd
  task automatic waitq();
    repeat (300) if (expq.size() != 0) @(posedge aclk);
  endtask : waitq
  task automatic drain();
    waitq();
    chk(32'(expq.size()), 32'h0);
    repeat (20) @(posedge aclk);
  endtask : drain
  always @(posedge aclk) begin
    pc_prev <= core_pc;
    if (aresetn && (core_vector_take === 1'b1 || core_reset === 1'b1)) begin
      if (core_vector_take === 1'b1)
        chk({16'h0, core_return_addr}, {16'h0, pc_prev});
      if (expq.size() == 0) chk({16'h0, core_vector}, 32'hFFFF);
      else chk({16'h0, core_vector}, {16'h0, expq.pop_front()});
      for (int i = 0; i < NSRC; i++)
        if (VT[i] === core_vector) src_flags[i] <= 1'b0;
    end
  end
  initial begin
    #300000;
    n_mismatch++;
    wrap_up();
  end
  initial begin
    logic [NSRC-1:0] m;
    void'($urandom(25));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    wr(REG_AUX_INT_ENABLE, 32'h8);
    rd(REG_AUX_INT_ENABLE, 32'h8, RESP_OKAY);
    rd(8'h40, 32'h0, RESP_SLVERR);
    wr(REG_ENABLE, 32'h3FD);
    for (int p = 0; p < 2; p++) begin
      m = p == 0 ? 10'h3FD : 10'($urandom) & 10'h3FD;
      svc_len <= 4'($urandom_range(9, 1));
      for (int i = 0; i < NSRC; i++)
        if (m[i]) expq.push_back(VT[i]);
      src_flags <= m;
      drain();
    end
    wr(REG_PRIO_HI, 32'hC);
    expq.push_back(VEC_T2);
    expq.push_back(VEC_T1);
    src_flags <= 10'h210;
    drain();
    wr(REG_PRIO_HI, 32'h0);
    wr(REG_POWER_CTRL, 32'h1);
    chk({31'h0, core_pc_halt}, 32'h1);
    chk({addr_latch_strobe, program_store_strobe_n}, 2'h3);
    expq.push_back(VEC_T0);
    src_flags <= 10'h004;
    drain();
    chk({31'h0, core_pc_halt}, 32'h0);
    rd(REG_POWER_CTRL, 32'h0, RESP_OKAY);
    wr(REG_POWER_CTRL, 32'h2);
    chk({31'h0, core_clock_stop}, 32'h1);
    chk({addr_latch_strobe, program_store_strobe_n}, 2'h0);
    src_flags <= 10'h004;
    repeat (30) @(posedge aclk);
    chk({31'h0, core_clock_stop}, 32'h1);
    expq.push_back(VEC_EXT0);
    expq.push_back(VEC_T0);
    ext_int0_n <= 1'b0;
    repeat (1030) @(posedge aclk);
    ext_int0_n <= 1'b1;
    drain();
    chk({31'h0, core_clock_stop}, 32'h0);
    rd(REG_POWER_CTRL, 32'h0, RESP_OKAY);
    wr(REG_POWER_CTRL, 32'h1);
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({core_pc_halt, addr_latch_strobe, program_store_strobe_n}, 3'h3);
    wr(REG_AUX_INT_ENABLE, 32'h8);
    svc_len <= 4'hF;
    brownout_low <= 1'b1;
    repeat (2) @(posedge aclk);
    brownout_low <= 1'b0;
    repeat (20) @(posedge aclk);
    expq.push_back(VEC_BO);
    brownout_low <= 1'b1;
    waitq();
    expq.push_back(VEC_RESET);
    wr(REG_AUX_INT_ENABLE, 32'h0);
    brownout_low <= 1'b0;
    drain();
    expq.push_back(VEC_RESET);
    brownout_low <= 1'b1;
    repeat (6) @(posedge aclk);
    brownout_low <= 1'b0;
    drain();
    wrap_up();
  end
endmodule : tb_interrupt_power_mode_control
